/* File: rtl/spi_clock_format_fault_irq.sv */
// Serial peripheral port: clock formats, mode fault and interrupt gating.
module spi_clock_format_fault_irq #(
    parameter int CLK_DIV = spi_fmt_pkg::CLK_DIV_RESET
) (
    // Clocks and reset
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire logic                  linkClk,
    // Configuration and software events
    input  wire spi_fmt_pkg::spi_cfg_t cfg,
    input  wire logic                  masterSetPulse,
    input  wire logic                  controlOneWrite,
    input  wire logic                  statusRead,
    input  wire logic                  txWrite,
    input  wire logic [7:0]            txData,
    input  wire logic                  dataRead,
    // Pins from outside
    input  wire logic                  clockIn,
    input  wire logic                  mosiIn,
    input  wire logic                  misoIn,
    input  wire logic                  selectIn_n,
    // Pins to outside
    output spi_fmt_pkg::spi_pads_t     pads,
    // Status and interrupt
    output logic                       masterSelect,
    output logic                       faultFlag,
    output logic                       rxFullFlag,
    output logic                       txEmptyFlag,
    output logic [7:0]                 rxData,
    output logic                       irqRequest
);
    import spi_fmt_pkg::*;

    // Slave logic on link clock: select and clock come from the other master
    typedef struct packed {
        logic [7:0] rxShift;
        logic [7:0] txShift;
        logic [2:0] bitCnt;
        logic       started;
        logic       misoOut;
        logic       doneToggle;
        logic [7:0] word;
        logic [7:0] txHold;
        logic [2:0] txSync;
        logic       selSync1;
        logic       selSync2;
        logic       clkSync1;
        logic       clkSync2;
        logic       clkLast;
        logic       mosiSync1;
        logic       mosiSync2;
        logic       mstSync1;
        logic       mstSync2;
    } link_state_t;

    typedef struct packed {
        mst_state_t  mst;
        logic [7:0]  divCnt;
        logic [4:0]  edgeCnt;
        logic        sclk;
        logic        sampled;
        logic [7:0]  shift;
        logic        master;
        logic        fault;
        logic        faultSeen;
        logic        rxFull;
        logic        rxFullSeen;
        logic        txEmpty;
        logic        txPending;
        logic [7:0]  txBuf;
        logic        txToggle;
        logic [7:0]  rxBuf;
        logic [2:0]  doneSync;
        logic [7:0]  slaveWord;
        logic [1:0]  selSync;
        logic [1:0]  misoSync;
        logic        selOut;
    } core_state_t;

    link_state_t lk, next_lk;
    core_state_t st, next_st;

    function automatic logic [7:0] shiftIn(input logic [7:0] v, input logic b,
                                           input logic lsbFirst);
        shiftIn = lsbFirst ? {b, v[7:1]} : {v[6:0], b};
    endfunction : shiftIn

    function automatic logic firstBit(input logic [7:0] v, input logic lsbFirst);
        firstBit = lsbFirst ? v[0] : v[7];
    endfunction : firstBit

    // Link pins pass two flops; a third clock flop finds its edges
    logic linkEdge;
    logic linkLead;
    logic sampleEdge;
    logic shiftEdge;
    logic linkIdle;
    assign linkEdge   = lk.clkSync2 ^ lk.clkLast;
    // Invert by polarity so the edge logic is the same for both levels
    assign linkLead   = lk.clkSync2 ^ cfg.clockPolarity;
    // Phase zero samples on leading edges, phase one on trailing edges
    assign sampleEdge = linkEdge && (linkLead ^ cfg.clockPhase);
    assign shiftEdge  = linkEdge && !(linkLead ^ cfg.clockPhase);
    // A master never answers as a slave
    assign linkIdle   = lk.selSync2 || lk.mstSync2;

    // Slave side: receive and reply on the link clock
    always_comb begin
        next_lk = lk;
        next_lk.selSync1  = selectIn_n;
        next_lk.selSync2  = lk.selSync1;
        next_lk.clkSync1  = clockIn;
        next_lk.clkSync2  = lk.clkSync1;
        next_lk.clkLast   = lk.clkSync2;
        next_lk.mosiSync1 = mosiIn;
        next_lk.mosiSync2 = lk.mosiSync1;
        next_lk.mstSync1  = st.master;
        next_lk.mstSync2  = lk.mstSync1;
        next_lk.txSync    = {lk.txSync[1:0], st.txToggle};
        // Reply word crosses by toggle; it is steady once the toggle lands
        if (lk.txSync[2] ^ lk.txSync[1]) begin
            next_lk.txHold = st.txBuf;
        end
        if (linkIdle) begin
            next_lk.bitCnt  = '0;
            next_lk.started = 1'b0;
            next_lk.txShift = lk.txHold;
            next_lk.misoOut = firstBit(lk.txHold, cfg.lsbFirstEnable);
        end else begin
            if (shiftEdge) begin
                if (cfg.clockPhase && !lk.started) begin
                    // First phase-one edge only puts the first bit out
                    next_lk.started = 1'b1;
                    next_lk.misoOut = firstBit(lk.txShift, cfg.lsbFirstEnable);
                end else begin
                    next_lk.txShift = shiftIn(lk.txShift, 1'b0, cfg.lsbFirstEnable);
                    next_lk.misoOut = firstBit(next_lk.txShift,
                                               cfg.lsbFirstEnable);
                end
            end
            if (sampleEdge) begin
                next_lk.rxShift = shiftIn(lk.rxShift, lk.mosiSync2,
                                          cfg.lsbFirstEnable);
                next_lk.bitCnt  = lk.bitCnt + 3'd1;
                if (lk.bitCnt == 3'(DATA_BITS - 1)) begin
                    // Byte done; select may stay low for the next one
                    next_lk.word       = next_lk.rxShift;
                    next_lk.doneToggle = ~lk.doneToggle;
                    next_lk.started    = 1'b0;
                    next_lk.txShift    = lk.txHold;
                end
            end
        end
    end

    // Select synchronisers reset to the deselected level
    always_ff @(posedge linkClk or negedge rst_n) begin
        if (!rst_n) begin
            lk <= '{selSync1: 1'b1, selSync2: 1'b1, default: '0};
        end else begin
            lk <= next_lk;
        end
    end

    logic faultInput;
    logic slaveDone;
    assign faultInput = st.master && cfg.faultDetectEnable
                        && !cfg.selectOutputEnable;
    assign slaveDone  = st.doneSync[2] ^ st.doneSync[1];

    // Master state machine and flags on the bus clock
    always_comb begin
        logic halfTick;
        logic xferDone;
        halfTick = 1'b0;
        xferDone = 1'b0;
        next_st = st;
        next_st.selSync  = {st.selSync[0], selectIn_n};
        next_st.misoSync = {st.misoSync[0], misoIn};
        next_st.doneSync = {st.doneSync[1:0], lk.doneToggle};
        next_st.slaveWord = lk.word;

        if (st.divCnt == 8'(CLK_DIV - 1)) begin
            next_st.divCnt = '0;
            halfTick = 1'b1;
        end else begin
            next_st.divCnt = st.divCnt + 8'd1;
        end

        if (masterSetPulse) begin
            next_st.master = 1'b1;
        end
        if (txWrite && st.txEmpty) begin
            next_st.txBuf = txData;
            next_st.txPending = 1'b1;
            next_st.txEmpty = 1'b0;
            // Tells the link side that a new reply word stands
            next_st.txToggle = ~st.txToggle;
        end

        case (st.mst)
            ST_IDLE: begin
                next_st.sclk = 1'b0;
                next_st.edgeCnt = '0;
                if (st.master && st.txPending && halfTick) begin
                    next_st.shift = st.txBuf;
                    next_st.txPending = 1'b0;
                    next_st.txEmpty = 1'b1;
                    next_st.selOut = 1'b0;
                    next_st.mst = cfg.clockPhase ? ST_LEAD : ST_SHIFT;
                end
            end
            ST_LEAD: begin
                if (halfTick) begin
                    next_st.mst = ST_SHIFT;
                end
            end
            ST_SHIFT: begin
                if (halfTick) begin
                    next_st.sclk = ~st.sclk;
                    next_st.edgeCnt = st.edgeCnt + 5'd1;
                    // Phase one samples on even edges, phase zero on odd
                    if (st.edgeCnt[0] ^ cfg.clockPhase) begin
                        if (st.edgeCnt != 5'd0) begin
                            next_st.shift = shiftIn(st.shift, st.sampled,
                                                    cfg.lsbFirstEnable);
                        end
                    end else begin
                        next_st.sampled = st.misoSync[1];
                    end
                    if (st.edgeCnt == 5'(EDGE_COUNT - 1)) begin
                        next_st.mst = ST_TRAIL;
                    end
                end
            end
            ST_TRAIL: begin
                if (halfTick) begin
                    // Phase zero already took its eighth bit at the last edge
                    if (cfg.clockPhase) begin
                        next_st.shift = shiftIn(st.shift, st.sampled,
                                                cfg.lsbFirstEnable);
                    end
                    next_st.selOut = 1'b1;
                    next_st.mst = ST_IDLE;
                    xferDone = 1'b1;
                end
            end
            default: begin
                next_st.mst = ST_IDLE;
            end
        endcase

        if (xferDone || slaveDone) begin
            next_st.rxBuf = xferDone ? next_st.shift : st.slaveWord;
        end

        // Flag clear sequences; a set in the same cycle wins
        if (statusRead && st.rxFull) begin
            next_st.rxFullSeen = 1'b1;
        end
        if (dataRead && st.rxFullSeen) begin
            next_st.rxFull = 1'b0;
            next_st.rxFullSeen = 1'b0;
        end
        if (statusRead && st.fault) begin
            next_st.faultSeen = 1'b1;
        end
        if (controlOneWrite && st.faultSeen) begin
            next_st.fault = 1'b0;
            next_st.faultSeen = 1'b0;
        end
        if (xferDone || slaveDone) begin
            next_st.rxFull = 1'b1;
        end
        if (faultInput && !st.selSync[1]) begin
            next_st.fault = 1'b1;
            next_st.master = 1'b0;
            next_st.mst = ST_IDLE;
            next_st.selOut = 1'b1;
            next_st.sclk = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '{mst: ST_IDLE, txEmpty: 1'b1, selOut: 1'b1, default: '0};
        end else begin
            st <= next_st;
        end
    end

    // Pads; enables active low
    always_comb begin
        logic slaveActive;
        slaveActive = !st.master && !lk.selSync2;
        pads.clockOut  = st.sclk ^ cfg.clockPolarity;
        pads.clockOe_n = !st.master || st.fault;
        pads.mosiOut   = firstBit(st.shift, cfg.lsbFirstEnable);
        pads.mosiOe_n  = !st.master || st.fault;
        pads.misoOut   = lk.misoOut;
        pads.misoOe_n  = !slaveActive || (st.fault && !cfg.bidirMode);
        pads.selectOut = st.selOut;
        pads.selectOe_n = !(st.master && cfg.faultDetectEnable
                            && cfg.selectOutputEnable);
    end

    assign masterSelect = st.master;
    assign faultFlag    = st.fault;
    assign rxFullFlag   = st.rxFull;
    assign txEmptyFlag  = st.txEmpty;
    assign rxData       = st.rxBuf;

    logic rxIrq;
    logic txIrq;
    assign rxIrq        = cfg.rxFaultIrqEnable && (st.rxFull || st.fault);
    assign txIrq        = cfg.txEmptyIrqEnable && st.txEmpty;
    assign irqRequest   = rxIrq || txIrq;
endmodule : spi_clock_format_fault_irq

/* File: rtl/spi_fmt_pkg.sv */
// Shared constants and carrier types for the serial clock-format block.
package spi_fmt_pkg;
    localparam int DATA_BITS     = 8;
    localparam int CLK_DIV_RESET = 4;
    localparam int EDGE_COUNT    = 2 * DATA_BITS;
    localparam logic [7:0] DATA_RESET = 8'h00;

    // Static configuration from software
    typedef struct packed {
        logic clockPolarity;
        logic clockPhase;
        logic lsbFirstEnable;
        logic faultDetectEnable;
        logic selectOutputEnable;
        logic bidirMode;
        logic rxFaultIrqEnable;
        logic txEmptyIrqEnable;
    } spi_cfg_t;

    // Pad-side signals; enables are active low
    typedef struct packed {
        logic clockOut;
        logic clockOe_n;
        logic mosiOut;
        logic mosiOe_n;
        logic misoOut;
        logic misoOe_n;
        logic selectOut;
        logic selectOe_n;
    } spi_pads_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_LEAD  = 2'b01,
        ST_SHIFT = 2'b11,
        ST_TRAIL = 2'b10
    } mst_state_t;
endpackage : spi_fmt_pkg

/* File: test/spi_far_slave.sv */
// Far-side slave device answering master transfers.
module spi_far_slave (
    // Pins from the master
    input  wire logic       selN,
    input  wire logic       sck,
    input  wire logic       mosi,
    // Format and reply byte
    input  wire logic       cpol,
    input  wire logic       cpha,
    input  wire logic       lsb,
    input  wire logic [7:0] txByte,
    // Pin to the master and received byte
    output logic            miso,
    output logic [7:0]      rxByte
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] sh;
    logic       smp;
    int         n;
    wire        lead = sck ^ cpol;
    initial miso = 1'b1;
    task automatic shiftOut();
        if (n > 0) sh = lsb ? {smp, sh[7:1]} : {sh[6:0], smp};
        miso = lsb ? sh[0] : sh[7];
        n++;
    endtask : shiftOut
    always @(negedge selN) begin
        sh = txByte;
        n = 0;
        if (!cpha) shiftOut();
    end
    always @(posedge lead) if (!selN) begin
        if (cpha) shiftOut();
        else smp = mosi;
    end
    always @(negedge lead) if (!selN) begin
        if (cpha) smp = mosi;
        else shiftOut();
    end
    always @(posedge selN) begin
        if (cpha) sh = lsb ? {smp, sh[7:1]} : {sh[6:0], smp};
        rxByte = sh;
        // Released line must not keep the last bit
        miso = ~miso;
    end
endmodule : spi_far_slave

/* File: test/spi_fmt_monitor.sv */
// Concurrent checks on the serial port block's pins, flags and request.
module spi_fmt_monitor (
    // Clock and reset
    input wire logic                  clk,
    input wire logic                  rst_n,
    // Observed ports
    input wire spi_fmt_pkg::spi_cfg_t  cfg,
    input wire logic                  controlOneWrite,
    input wire spi_fmt_pkg::spi_pads_t pads,
    input wire logic                  masterSelect,
    input wire logic                  faultFlag,
    input wire logic                  rxFullFlag,
    input wire logic                  txEmptyFlag,
    input wire logic                  irqRequest
);
    import spi_fmt_pkg::*;
    logic [4:0] edgeCnt;
    logic       lastClk;
    // Clock edges seen while select is low
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            edgeCnt <= '0;
            lastClk <= 1'b0;
        end else begin
            lastClk <= pads.clockOut;
            if (pads.selectOut) edgeCnt <= '0;
            else if (lastClk != pads.clockOut) edgeCnt <= edgeCnt + 5'd1;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    idle_clock_a: assert property (
        masterSelect && pads.selectOut && $stable(cfg.clockPolarity)
        |-> pads.clockOut == cfg.clockPolarity) else $error("idle clock level wrong");
    edge_count_a: assert property (
        $rose(pads.selectOut) && masterSelect |-> edgeCnt == 5'd16)
        else $error("clock edge count per byte wrong");
    lead_quiet_a: assert property (
        $fell(pads.selectOut) |=> $stable(pads.clockOut)[*2])
        else $error("clock moved right after select");
    irq_gate_a: assert property (
        irqRequest == ((rxFullFlag || faultFlag) && cfg.rxFaultIrqEnable
                       || txEmptyFlag && cfg.txEmptyIrqEnable)) else $error("irq gating wrong");
    sel_drive_a: assert property (
        !pads.selectOe_n |-> masterSelect && cfg.faultDetectEnable && cfg.selectOutputEnable)
        else $error("select driven without enables");
    fault_gate_a: assert property (
        $rose(faultFlag) |-> $past(masterSelect) && cfg.faultDetectEnable
                             && !cfg.selectOutputEnable) else $error("fault outside fault mode");
    fault_drop_a: assert property (
        $rose(faultFlag) |-> !masterSelect && pads.clockOe_n && pads.mosiOe_n)
        else $error("fault left master or drivers on");
    miso_off_a: assert property (
        $rose(faultFlag) && !cfg.bidirMode |-> pads.misoOe_n) else $error("miso driven on fault");
    fault_clear_a: assert property (
        $fell(faultFlag) |-> $past(controlOneWrite)) else $error("fault cleared without write");
endmodule : spi_fmt_monitor

bind spi_clock_format_fault_irq spi_fmt_monitor u_spi_fmt_monitor (
    .clk, .rst_n, .cfg, .controlOneWrite, .pads, .masterSelect, .faultFlag,
    .rxFullFlag, .txEmptyFlag, .irqRequest
);

/* File: test/tb_top.sv */
// Self-checking bench for the serial clock-format block.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import spi_fmt_pkg::*;
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    logic       linkClk = 1'b0;
    spi_cfg_t   cfg = '0;
    logic       masterSetPulse = 1'b0;
    logic       controlOneWrite = 1'b0;
    logic       statusRead = 1'b0;
    logic       txWrite = 1'b0;
    logic [7:0] txData = 8'h00;
    logic       dataRead = 1'b0;
    logic       clockIn = 1'b0;
    logic       mosiIn = 1'b0;
    logic       selectIn_n = 1'b1;
    spi_pads_t  pads;
    logic       masterSelect, faultFlag, rxFullFlag, txEmptyFlag, irqRequest, misoIn;
    logic [7:0] rxData, farRx;
    int         error_cnt = 0;
    int         checked = 0;
    localparam logic [7:0] SLV_BYTE = 8'h96;
    localparam logic [7:0] SLV_NEXT = 8'h3B;
    // Last byte the master loop writes: 8'hA3 ^ 8'h07
    localparam logic [7:0] SLV_TX   = 8'hA4;
    always #5 clk = ~clk;
    initial #1.3 forever #3 linkClk = ~linkClk;
    spi_clock_format_fault_irq #(.CLK_DIV(4)) u_spi_clock_format_fault_irq (
        .clk, .rst_n, .linkClk, .cfg, .masterSetPulse, .controlOneWrite, .statusRead,
        .txWrite, .txData, .dataRead, .clockIn, .mosiIn, .misoIn, .selectIn_n, .pads,
        .masterSelect, .faultFlag, .rxFullFlag, .txEmptyFlag, .rxData, .irqRequest);
    spi_far_slave u_spi_far_slave (.selN(pads.selectOe_n | pads.selectOut),
        .sck(pads.clockOut), .mosi(pads.mosiOut), .cpol(cfg.clockPolarity),
        .cpha(cfg.clockPhase), .lsb(cfg.lsbFirstEnable), .txByte(8'h5C),
        .miso(misoIn), .rxByte(farRx));
    task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic tick(input int n = 1);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic pulse(ref logic s);
        s = 1'b1;
        tick();
        s = 1'b0;
        tick();
    endtask : pulse
    task automatic xfer(input logic [2:0] fmt, input logic [7:0] d);
        {cfg.clockPolarity, cfg.clockPhase, cfg.lsbFirstEnable} = fmt;
        tick(2);
        txData = d;
        pulse(txWrite);
        for (int i = 0; i < 400 && rxFullFlag !== 1'b1; i++) tick();
        chk("rxFull", 8'(rxFullFlag), 8'h01);
        chk("rxData", rxData, 8'h5C);
        chk("farRx", farRx, d);
        pulse(statusRead);
        pulse(dataRead);
    endtask : xfer
    task automatic final_report();
        if (error_cnt == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : final_report
    initial begin
        #60000;
        error_cnt++;
        final_report();
    end
    initial begin
        tick(16);
        rst_n = 1'b1;
        cfg.faultDetectEnable = 1'b1;
        cfg.selectOutputEnable = 1'b1;
        cfg.txEmptyIrqEnable = 1'b1;
        tick(2);
        chk("txIrq", 8'(irqRequest), 8'h01);
        pulse(masterSetPulse);
        for (int f = 0; f < 8; f++) xfer(3'(f), 8'hA3 ^ 8'(f));
        selectIn_n = 1'b0;
        tick(5);
        chk("noFault", 8'(faultFlag), 8'h00);
        cfg.selectOutputEnable = 1'b0;
        cfg.txEmptyIrqEnable = 1'b0;
        tick(5);
        chk("fault", {6'h0, faultFlag, masterSelect}, 8'h02);
        chk("drivers", {6'h0, pads.clockOe_n, pads.mosiOe_n}, 8'h03);
        chk("irqMasked", 8'(irqRequest), 8'h00);
        cfg.rxFaultIrqEnable = 1'b1;
        tick();
        chk("irqFault", 8'(irqRequest), 8'h01);
        selectIn_n = 1'b1;
        pulse(controlOneWrite);
        chk("faultHeld", 8'(faultFlag), 8'h01);
        pulse(statusRead);
        pulse(controlOneWrite);
        chk("faultClr", 8'(faultFlag), 8'h00);
        {cfg.clockPolarity, cfg.clockPhase, cfg.lsbFirstEnable} = 3'b000;
        tick(2);
        selectIn_n = 1'b0;
        tick(2);
        chk("misoOn", 8'(pads.misoOe_n), 8'h00);
        for (int b = 7; b >= 0; b--) begin
            mosiIn = SLV_BYTE[b];
            tick(3);
            chk("slaveMiso", 8'(pads.misoOut), 8'(SLV_TX[b]));
            clockIn = 1'b1;
            tick(3);
            clockIn = 1'b0;
        end
        tick(3);
        selectIn_n = 1'b1;
        tick(20);
        chk("slaveRx", rxData, SLV_BYTE);
        cfg.clockPhase = 1'b1;
        tick(2);
        selectIn_n = 1'b0;
        tick(2);
        for (int k = 0; k < 2; k++) begin
            for (int b = 7; b >= 0; b--) begin
                clockIn = 1'b1;
                mosiIn = (k == 0) ? SLV_BYTE[b] : SLV_NEXT[b];
                tick(3);
                chk("slaveMiso1", 8'(pads.misoOut), 8'(SLV_TX[b]));
                clockIn = 1'b0;
                tick(3);
            end
            tick(20);
            chk("slaveRx1", rxData, (k == 0) ? SLV_BYTE : SLV_NEXT);
        end
        selectIn_n = 1'b1;
        tick(2);
        pulse(masterSetPulse);
        chk("remaster", {7'h0, masterSelect}, 8'h01);
        final_report();
    end
endmodule : tb_top
